// *** rtl/pllsc_core.sv ***
/*
 synthesizer digital core: latches, reference and feedback dividers,
 phase comparator, lock detect, output select, power down, fast lock.
 assumes reference and rf inputs arrive as pins, synchronised here;
 rf input below an eighth of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pllsc_core
    import pllsc_pkg::*;
#(
    parameter bit LARGE_PRESC = 1'b1
)(
    input  wire logic  ref_clk,
    input  wire logic  reset,
    input  wire logic  link_clk,
    input  wire logic  serial_data,
    input  wire logic  load_strobe,
    input  wire logic  ref_in,
    input  wire logic  rf_in,
    input  wire logic  chip_enable,
    output logic       pump_up,
    output logic       pump_down,
    output logic       pump_tristate,
    output logic       pump_gain_bit,
    output logic       diag_select_out,
    output logic       diag_select_oe,
    output logic       loop_filter_switch_out,
    output logic       ref_shunt_switch,
    output logic       ref_series_switch,
    output logic       powered_down
);
    logic [WORD_W-1:0] word;
    logic              word_valid;

    pllsc_shift_link u_link (
        .link_clk    (link_clk),
        .serial_data (serial_data),
        .load_strobe (load_strobe),
        .ref_clk     (ref_clk),
        .reset       (reset),
        .word_out    (word),
        .word_valid  (word_valid)
    );

    typedef struct packed {
        logic [2:0]  ref_s;
        logic [2:0]  rf_s;
        logic [1:0]  ce_s;
        logic [20:0] ref_latch;
        logic [20:0] fb_latch;
        logic [20:0] func_latch;
        logic [13:0] rcnt;
        logic [5:0]  pcnt;
        logic [12:0] bcnt;
        logic [4:0]  acnt;
        logic        r_pulse;
        logic        n_pulse;
        logic        up;
        logic        dn;
        logic [3:0]  abl;
        logic [3:0]  err;
        logic        err_seen;
        logic [2:0]  good;
        logic        dlock;
        logic        pd_sync_arm;
        logic        pd_prog;
        logic [11:0] fl_tick;
        logic [4:0]  fl_cnt;
        logic        pump_up;
        logic        pump_down;
        logic        pump_tri;
        logic        gain;
        logic        mux;
        logic        mux_oe;
        logic        fl_out;
        logic        shunt;
        logic        series;
        logic        pdn;
    } pllsc_state_t;

    pllsc_state_t s;
    pllsc_state_t next_s;

    logic       pd_now;
    logic       hold_cnt;
    logic [5:0] modulus;
    logic [2:0] lock_need;
    logic       alock;
    logic       cycle_end;

    always_comb begin
        next_s = s;
        next_s.ref_s = {s.ref_s[1:0], ref_in};
        next_s.rf_s  = {s.rf_s[1:0], rf_in};
        next_s.ce_s  = {s.ce_s[0], chip_enable};
        next_s.r_pulse = 1'b0;
        next_s.n_pulse = 1'b0;

        if (word_valid) begin
            if (word[1:0] == ADDR_REF) begin // R4
                next_s.ref_latch = word; // R5
            end else if (word[1:0] == ADDR_FB) begin
                next_s.fb_latch = word; // R22
            end else begin
                next_s.func_latch = word; // function and init share layout
            end
        end

        // programmed power down: async at once, sync after next pump event
        pd_now = 1'b0;
        if (!s.ce_s[1]) begin
            pd_now = 1'b1; // R17
        end else if (s.func_latch[F_PD1_POS]) begin
            if (!s.func_latch[F_PD2_POS]) begin
                pd_now = 1'b1;
            end else begin
                pd_now = s.pd_prog;
            end
        end
        if (s.func_latch[F_PD1_POS] && s.func_latch[F_PD2_POS]
            && (s.up || s.dn)) begin
            next_s.pd_sync_arm = 1'b1;
        end
        if (s.pd_sync_arm && !s.up && !s.dn) begin
            next_s.pd_prog = 1'b1;
        end
        if (!s.func_latch[F_PD1_POS]) begin
            next_s.pd_sync_arm = 1'b0;
            next_s.pd_prog     = 1'b0;
        end
        next_s.pdn    = pd_now;
        next_s.shunt  = pd_now; // R18
        next_s.series = !pd_now; // R18

        hold_cnt = pd_now || s.func_latch[F_RESET_POS];
        modulus  = LARGE_PRESC ? PRESC_LARGE : PRESC_SMALL; // R10

        // reference divider, one pulse per ref_divide_value edges
        if (hold_cnt) begin
            next_s.rcnt = 14'h0001; // R21
        end else if (s.ref_s[1] && !s.ref_s[2]) begin
            if (s.rcnt >= s.ref_latch[RDIV_HI:RDIV_LO]) begin // R6
                next_s.rcnt    = 14'h0001;
                next_s.r_pulse = 1'b1;
            end else begin
                next_s.rcnt = s.rcnt + 14'h0001;
            end
        end

        // pulse swallow: modulus+1 while swallow counts, then modulus
        if (hold_cnt) begin
            next_s.pcnt = 6'h01; // R21
            next_s.bcnt = 13'h0001;
            next_s.acnt = 5'h00;
        end else if (s.rf_s[1] && !s.rf_s[2]) begin
            if (s.pcnt >= ((s.acnt < s.fb_latch[SWAL_HI:SWAL_LO]) ?
                           modulus + 6'h01 : modulus)) begin // R9
                next_s.pcnt = 6'h01;
                if (s.acnt < s.fb_latch[SWAL_HI:SWAL_LO]) begin
                    next_s.acnt = s.acnt + 5'h01;
                end
                if (s.bcnt >= s.fb_latch[MAIN_HI:MAIN_LO]) begin
                    next_s.bcnt    = 13'h0001;
                    next_s.acnt    = 5'h00;
                    next_s.n_pulse = 1'b1;
                end else begin
                    next_s.bcnt = s.bcnt + 13'h0001;
                end
            end else begin
                next_s.pcnt = s.pcnt + 6'h01;
            end
        end

        // phase comparator: clear both after overlap delay, new edge wins
        if (s.up && s.dn) begin
            if (s.abl >= ABL_CYC) begin // R12
                next_s.up  = 1'b0;
                next_s.dn  = 1'b0;
                next_s.abl = 4'h0;
            end else begin
                next_s.abl = s.abl + 4'h1;
            end
        end
        if (s.r_pulse) begin
            next_s.up = 1'b1; // R11
        end
        if (s.n_pulse) begin
            next_s.dn = 1'b1;
        end
        if (s.up ^ s.dn) begin
            if (s.err != 4'hf) begin
                next_s.err = s.err + 4'h1;
            end
        end
        cycle_end = s.up && s.dn && (s.abl >= ABL_CYC);

        lock_need = s.ref_latch[PREC_POS] ? LOCK_CNT_HI : LOCK_CNT_LO; // R20
        if (cycle_end) begin
            next_s.err = 4'h0;
            if (s.err < LOCK_IN_CYC) begin
                if (s.good != 3'h7) begin
                    next_s.good = s.good + 3'h1;
                end
                if (s.good + 3'h1 >= lock_need) begin
                    next_s.dlock = 1'b1; // R14
                end
            end else begin
                next_s.good = 3'h0;
            end
            if (s.err > LOCK_OUT_CYC) begin
                next_s.dlock = 1'b0; // R15
            end
        end
        if (pd_now) begin
            next_s.up    = 1'b0;
            next_s.dn    = 1'b0;
            next_s.abl   = 4'h0;
            next_s.err   = 4'h0;
            next_s.good  = 3'h0;
            next_s.dlock = 1'b0;
        end

        next_s.pump_tri  = pd_now || s.func_latch[F_TRI_POS]; // R17
        next_s.pump_up   = !next_s.pump_tri &&
                           (s.func_latch[F_POL_POS] ? s.up : s.dn);
        next_s.pump_down = !next_s.pump_tri &&
                           (s.func_latch[F_POL_POS] ? s.dn : s.up);

        // fast lock: gain bit from feedback latch, mode 2 times it out
        if (word_valid && word[1:0] == ADDR_FB) begin
            next_s.gain    = word[GAIN_POS];
            next_s.fl_cnt  = 5'h00;
            next_s.fl_tick = 12'h000;
        end else if (s.gain && s.func_latch[F_FLEN_POS]
                     && s.func_latch[F_FLMODE_POS]) begin
            next_s.fl_tick = s.fl_tick + 12'h001;
            if (s.fl_tick == FL_TICK_BASE) begin
                next_s.fl_tick = 12'h000;
                next_s.fl_cnt = s.fl_cnt + 5'h01;
                if (s.fl_cnt >= {1'b0, s.func_latch[F_TC_HI:F_TC_LO]}) begin
                    next_s.gain = 1'b0;
                end
            end
        end
        if (s.func_latch[F_FLEN_POS]) begin
            next_s.fl_out = !s.gain; // R19
        end else begin
            next_s.fl_out = s.func_latch[F_FLMODE_POS];
        end

        alock = !(s.up ^ s.dn); // R16
        next_s.mux_oe = 1'b1;
        case (s.func_latch[F_MUX_HI:F_MUX_LO]) // R13
            MUX_DLOCK: next_s.mux = s.dlock;
            MUX_NDIV:  next_s.mux = s.n_pulse;
            MUX_HIGH:  next_s.mux = 1'b1;
            MUX_RDIV:  next_s.mux = s.r_pulse;
            MUX_ALOCK: begin
                next_s.mux    = 1'b0;
                next_s.mux_oe = !alock;
            end
            default:   next_s.mux = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s            <= '0;
            s.rcnt       <= 14'h0001;
            s.pcnt       <= 6'h01;
            s.bcnt       <= 13'h0001;
            s.ref_latch  <= LATCH_RESET;
            s.fb_latch   <= LATCH_RESET;
            s.func_latch <= LATCH_RESET;
            s.pump_tri   <= 1'b1;
            s.series     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pump_up                = s.pump_up;
    assign pump_down              = s.pump_down;
    assign pump_tristate          = s.pump_tri;
    assign pump_gain_bit          = s.gain;
    assign diag_select_out        = s.mux;
    assign diag_select_oe         = s.mux_oe;
    assign loop_filter_switch_out = s.fl_out;
    assign ref_shunt_switch       = s.shunt;
    assign ref_series_switch      = s.series;
    assign powered_down           = s.pdn;

    property p_load_ref;
        @(posedge ref_clk) disable iff (reset)
        word_valid && word[1:0] == ADDR_REF |=> s.ref_latch == $past(word);
    endproperty
    a_load_ref: assert property (p_load_ref) else $error("ref latch not loaded"); // R5

    property p_load_fb;
        @(posedge ref_clk) disable iff (reset)
        word_valid && word[1:0] == ADDR_FB |=> s.fb_latch == $past(word);
    endproperty
    a_load_fb: assert property (p_load_fb) else $error("feedback latch not loaded"); // R22

    property p_addr_one;
        @(posedge ref_clk) disable iff (reset)
        word_valid && word[1] |=> $stable(s.ref_latch) && $stable(s.fb_latch);
    endproperty
    a_addr_one: assert property (p_addr_one) else $error("wrong latch written"); // R4

    property p_hold;
        @(posedge ref_clk) disable iff (reset)
        hold_cnt |=> s.rcnt == 14'h0001 && s.bcnt == 13'h0001;
    endproperty
    a_hold: assert property (p_hold) else $error("counters not held"); // R21

    property p_ce_off;
        @(posedge ref_clk) disable iff (reset)
        !s.ce_s[1] |=> s.pump_tri && s.shunt && !s.series && !s.pump_up;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("power down not applied"); // R17

    sequence s_both_on;
        s.up && s.dn;
    endsequence
    property p_abl;
        @(posedge ref_clk) disable iff (reset)
        $rose(s.up && s.dn) && !pd_now |-> s_both_on [*1] ##0 (s.abl == 4'h0);
    endproperty
    a_abl: assert property (p_abl) else $error("overlap count not fresh"); // R12

    property p_unlock;
        @(posedge ref_clk) disable iff (reset)
        cycle_end && s.err > LOCK_OUT_CYC |=> !s.dlock;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept on error"); // R15

    property p_lock_rise;
        @(posedge ref_clk) disable iff (reset)
        $rose(s.dlock) |-> $past(cycle_end) && $past(s.good) + 3'h1 >= $past(lock_need);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock set too early"); // R14

    property p_dlock_mux;
        @(posedge ref_clk) disable iff (reset)
        s.func_latch[F_MUX_HI:F_MUX_LO] == MUX_DLOCK |=> s.mux == $past(s.dlock);
    endproperty
    a_dlock_mux: assert property (p_dlock_mux) else $error("mux not lock"); // R13
endmodule
`default_nettype wire

// *** rtl/pllsc_pkg.sv ***
/*
 package for the serially programmed synthesizer core: latch field positions,
 latch addresses, prescaler and timing constants.
 assumes ref_clk at 250 MHz and a serial link clock from the host.
*/
// Overview of operation
// R1 - shift one data bit per serial clock rise
// R2 - msb first, last two bits select latch
// R3 - load strobe rise copies word to one latch
// R4 - addresses pick ref, feedback, function, init latch
// R5 - ref latch: precision 20, test 19:16, divide 15:2
// R6 - reference divider divides by 1 to 16383
// R7 - host programs main counter 3 to 8191
// R8 - host programs swallow counter 0 to 31
// R9 - feedback divides by modulus times main plus swallow
// R10 - prescaler modulus 8/9 or 32/33 variant
// R11 - phase comparator drives up and down demands
// R12 - minimum reset pulse about 3ns on both
// R13 - output select field chooses diagnostic output
// R14 - lock asserts after consecutive sub-15ns cycles
// R15 - lock drops on error above 25ns
// R16 - analog lock open drain pulses low on error
// R17 - chip enable low powers down, tristates pump
// R18 - power down closes shunt, opens series switches
// R19 - fast lock switch output drives loop resistor
// R20 - precision bit picks three or five cycles
// R21 - divider reset bit holds counters in reset
// R22 - feedback latch: gain 20, main 19:7, swallow 6:2
// R23 - host holds strobe low while shifting, pulses once
package pllsc_pkg;
    localparam int          WORD_W       = 21;
    localparam logic [1:0]  ADDR_REF     = 2'h0;
    localparam logic [1:0]  ADDR_FB      = 2'h1;
    localparam logic [1:0]  ADDR_FUNC    = 2'h2;
    localparam logic [1:0]  ADDR_INIT    = 2'h3;
    localparam int          PREC_POS     = 20;
    localparam int          TEST_HI      = 19;
    localparam int          TEST_LO      = 16;
    localparam int          RDIV_HI      = 15;
    localparam int          RDIV_LO      = 2;
    localparam int          GAIN_POS     = 20;
    localparam int          MAIN_HI      = 19;
    localparam int          MAIN_LO      = 7;
    localparam int          SWAL_HI      = 6;
    localparam int          SWAL_LO      = 2;
    localparam int          F_RESET_POS  = 2;
    localparam int          F_PD1_POS    = 3;
    localparam int          F_MUX_HI     = 6;
    localparam int          F_MUX_LO     = 4;
    localparam int          F_POL_POS    = 7;
    localparam int          F_TRI_POS    = 8;
    localparam int          F_FLEN_POS   = 9;
    localparam int          F_FLMODE_POS = 11;
    localparam int          F_TC_HI      = 14;
    localparam int          F_TC_LO      = 11;
    localparam int          F_PD2_POS    = 19;
    localparam logic [20:0] LATCH_RESET  = 21'h000000;
    // prescaler core modulus (divide-by-4/5 core scaled by variant)
    localparam logic [5:0]  PRESC_SMALL  = 6'h08;
    localparam logic [5:0]  PRESC_LARGE  = 6'h20;
    // output select codes
    localparam logic [2:0]  MUX_LOW      = 3'h0;
    localparam logic [2:0]  MUX_DLOCK    = 3'h1;
    localparam logic [2:0]  MUX_NDIV     = 3'h2;
    localparam logic [2:0]  MUX_HIGH     = 3'h3;
    localparam logic [2:0]  MUX_RDIV     = 3'h4;
    localparam logic [2:0]  MUX_ALOCK    = 3'h5;
    localparam int          CLK_MHZ      = 250;
    localparam int          PERIOD_PS    = 1000000 / CLK_MHZ;
    localparam int          ABL_PS       = 3000;
    localparam int          LOCK_IN_PS   = 15000;
    localparam int          LOCK_OUT_PS  = 25000;
    // least time rounds up, longest rounds down
    localparam logic [3:0]  ABL_CYC      = 4'((ABL_PS + PERIOD_PS - 1) / PERIOD_PS);
    localparam logic [3:0]  LOCK_IN_CYC  = 4'(LOCK_IN_PS / PERIOD_PS);
    localparam logic [3:0]  LOCK_OUT_CYC = 4'(LOCK_OUT_PS / PERIOD_PS);
    localparam logic [2:0]  LOCK_CNT_LO  = 3'h3;
    localparam logic [2:0]  LOCK_CNT_HI  = 3'h5;
    localparam logic [11:0] FL_TICK_BASE = 12'h3ff;
endpackage

// *** rtl/pllsc_shift_link.sv ***
/*
 serial link front end on the link clock: shift register and word capture.
 assumes the host keeps the load strobe low while shifting.
*/
`timescale 1ns/10ps
`default_nettype none
module pllsc_shift_link
    import pllsc_pkg::*;
(
    input  wire logic              link_clk,
    input  wire logic              serial_data,
    input  wire logic              load_strobe,
    input  wire logic              ref_clk,
    input  wire logic              reset,
    output logic [WORD_W-1:0]      word_out,
    output logic                   word_valid
);
    logic [WORD_W-1:0] shift_reg = '0;
    logic [WORD_W-1:0] held_word = '0;
    logic              load_tog  = 1'b0;
    logic [2:0]        tog_sync;

    // msb first: older bits move up
    always_ff @(posedge link_clk) begin
        shift_reg <= {shift_reg[WORD_W-2:0], serial_data}; // R1 R2
    end

    // strobe rise freezes the word, toggle flags it to the core
    always_ff @(posedge load_strobe) begin
        held_word <= shift_reg; // R3
        load_tog  <= ~load_tog;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tog_sync   <= 3'h0;
            word_out   <= '0;
            word_valid <= 1'b0;
        end else begin
            tog_sync   <= {tog_sync[1:0], load_tog};
            word_valid <= tog_sync[2] ^ tog_sync[1];
            // word stable long before the toggle crosses
            if (tog_sync[2] ^ tog_sync[1]) begin
                word_out <= held_word;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/pllsc_host_model.sv ***
/*
 host side of the three-wire programming link: makes the link clock,
 shifts a word out and pulses the load strobe.
 assumes the link clock idles low between frames and data has no pull.
*/
`timescale 1ns/10ps
`default_nettype none
module pllsc_host_model
    import pllsc_pkg::*;
(
    output logic link_clk,
    output logic serial_data,
    output logic load_strobe
);
    localparam realtime HALF_NS = 62.5;

    initial begin
        link_clk = 1'b0;
        serial_data = 1'b1;
        load_strobe = 1'b0;
    end

    task automatic send_word(input logic [WORD_W-1:0] w);
        #17;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            serial_data = w[i];
            #HALF_NS link_clk = 1'b1;
            #HALF_NS link_clk = 1'b0;
        end
        // released data line shows the inverse of its last bit
        serial_data = ~w[0];
        #HALF_NS load_strobe = 1'b1;
        #HALF_NS load_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 self-checking bench for the synthesizer core: programs latches through
 the host model and measures divided pulses, pump demands and power down.
 assumes the 8/9 prescaler variant and outputs settled a few clocks on.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pllsc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ref_in = 1'b0;
    logic rf_in = 1'b0;
    logic chip_enable = 1'b1;
    logic link_clk, serial_data, load_strobe;
    logic pump_up, pump_down, pump_tristate, pump_gain_bit;
    logic diag_select_out, diag_select_oe, loop_filter_switch_out;
    logic ref_shunt_switch, ref_series_switch, powered_down;
    int   n_mismatch = 0;
    int   cmp_count = 0;
    int   ref_cnt = 0;
    int   rf_cnt = 0;
    int   n_rise, n_up, n_dn, n_both, n_high, n_oe;
    logic counting = 1'b0;
    logic diag_q = 1'b0;

    always #2 ref_clk = ~ref_clk;

    pllsc_host_model u_pllsc_host_model (
        .link_clk    (link_clk),
        .serial_data (serial_data),
        .load_strobe (load_strobe)
    );

    pllsc_core #(.LARGE_PRESC(1'b0)) u_pllsc_core (
        .ref_clk                (ref_clk),
        .reset                  (reset),
        .link_clk               (link_clk),
        .serial_data            (serial_data),
        .load_strobe            (load_strobe),
        .ref_in                 (ref_in),
        .rf_in                  (rf_in),
        .chip_enable            (chip_enable),
        .pump_up                (pump_up),
        .pump_down              (pump_down),
        .pump_tristate          (pump_tristate),
        .pump_gain_bit          (pump_gain_bit),
        .diag_select_out        (diag_select_out),
        .diag_select_oe         (diag_select_oe),
        .loop_filter_switch_out (loop_filter_switch_out),
        .ref_shunt_switch       (ref_shunt_switch),
        .ref_series_switch      (ref_series_switch),
        .powered_down           (powered_down)
    );

    // reference period 8 clocks, rf period 10 clocks
    always @(posedge ref_clk) begin
        ref_cnt <= (ref_cnt == 3) ? 0 : ref_cnt + 1;
        rf_cnt <= (rf_cnt == 4) ? 0 : rf_cnt + 1;
        if (ref_cnt == 3) ref_in <= ~ref_in;
        if (rf_cnt == 4) rf_in <= ~rf_in;
    end

    always @(posedge ref_clk) begin
        if (counting) begin
            if (diag_select_out === 1'b1 && diag_q !== 1'b1) n_rise++;
            if (diag_select_out === 1'b1) n_high++;
            if (diag_select_oe === 1'b1) n_oe++;
            if (pump_up === 1'b1) n_up++;
            if (pump_down === 1'b1) n_dn++;
            if (pump_up === 1'b1 && pump_down === 1'b1) n_both++;
        end
        diag_q = diag_select_out;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [WORD_W-1:0] func_word(input logic [1:0] addr,
        input logic [2:0] mux, input logic rst, input logic pol, input logic flm);
        logic [WORD_W-1:0] w;
        w = '0;
        w[1:0] = addr;
        w[F_MUX_HI:F_MUX_LO] = mux;
        w[F_RESET_POS] = rst;
        w[F_POL_POS] = pol;
        w[F_FLMODE_POS] = flm;
        return w;
    endfunction

    function automatic logic [WORD_W-1:0] ref_word(input int r);
        logic [WORD_W-1:0] w;
        w = '0;
        w[RDIV_HI:RDIV_LO] = 14'(r);
        w[1:0] = ADDR_REF;
        return w;
    endfunction

    function automatic logic [WORD_W-1:0] fb_word(input int b, input int a);
        logic [WORD_W-1:0] w;
        w = '0;
        w[MAIN_HI:MAIN_LO] = 13'(b);
        w[SWAL_HI:SWAL_LO] = 5'(a);
        w[1:0] = ADDR_FB;
        return w;
    endfunction

    task automatic load(input logic [WORD_W-1:0] w);
        u_pllsc_host_model.send_word(w);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic measure(input int cycles);
        repeat (100) @(posedge ref_clk);
        @(negedge ref_clk);
        n_rise = 0;
        n_up = 0;
        n_dn = 0;
        n_both = 0;
        n_high = 0;
        n_oe = 0;
        counting = 1'b1;
        repeat (cycles) @(negedge ref_clk);
        counting = 1'b0;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        logic [WORD_W-1:0] words [4];
        logic              exp_out [4];
        int                bv [2];
        int                av [2];
        int                n;
        words = '{func_word(ADDR_FUNC, MUX_HIGH, 1'b0, 1'b1, 1'b0), ref_word(1),
                  fb_word(3, 0), func_word(ADDR_INIT, MUX_LOW, 1'b0, 1'b1, 1'b0)};
        exp_out = '{1'b1, 1'b1, 1'b1, 1'b0};
        bv = '{6, 3};
        av = '{5, 0};
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("tristate in reset", pump_tristate, 1'b1);
        check("series in reset", ref_series_switch, 1'b1);
        check("oe in reset", diag_select_oe, 1'b0);
        @(posedge ref_clk);
        reset <= 1'b0;
        $display("test reset done");
        // one write per latch address, only the function latches move the output
        for (int i = 0; i < 4; i++) begin
            load(words[i]);
            check("diag after load", diag_select_out, exp_out[i]);
        end
        $display("test latch addressing done");
        load(func_word(ADDR_FUNC, MUX_RDIV, 1'b0, 1'b1, 1'b0));
        for (int r = 1; r <= 5; r += 4) begin
            load(ref_word(r));
            measure(1920);
            check("ref pulses", (n_rise - 240 / r) inside {-1, 0, 1}, 1'b1);
        end
        $display("test reference divider done");
        load(func_word(ADDR_FUNC, MUX_NDIV, 1'b0, 1'b1, 1'b0));
        for (int i = 0; i < 2; i++) begin
            load(fb_word(bv[i], av[i]));
            n = 8 * bv[i] + av[i];
            measure(5300);
            check("fb pulses", (n_rise - 530 / n) inside {-1, 0, 1}, 1'b1);
        end
        $display("test feedback divider done");
        load(ref_word(1));
        load(func_word(ADDR_FUNC, MUX_RDIV, 1'b1, 1'b1, 1'b0));
        measure(400);
        check("pulses held in reset", n_rise, 0);
        load(func_word(ADDR_FUNC, MUX_RDIV, 1'b0, 1'b1, 1'b0));
        measure(640);
        check("pulses resumed", (n_rise - 80) inside {-1, 0, 1}, 1'b1);
        $display("test counter reset done");
        // feedback 30 times slower than the reference: up dominates at positive polarity
        for (int p = 0; p < 2; p++) begin
            load(func_word(ADDR_FUNC, MUX_LOW, 1'b0, p[0], 1'b0));
            measure(2000);
            check("up beats down", n_up > n_dn, p[0]);
            check("down beats up", n_dn > n_up, !p[0]);
            check("both high seen", n_both > 0, 1'b1);
        end
        load(func_word(ADDR_FUNC, MUX_DLOCK, 1'b0, 1'b1, 1'b0));
        measure(2000);
        check("no lock when off", n_high, 0);
        load(func_word(ADDR_FUNC, MUX_ALOCK, 1'b0, 1'b1, 1'b0));
        measure(2000);
        check("analog lock pulls low", n_oe > 1000, 1'b1);
        check("analog lock never high", n_high, 0);
        $display("test phase comparator done");
        for (int f = 1; f >= 0; f--) begin
            load(func_word(ADDR_FUNC, MUX_HIGH, 1'b0, 1'b1, f[0]));
            check("fast lock pin", loop_filter_switch_out, f[0]);
        end
        load(func_word(ADDR_FUNC, MUX_HIGH, 1'b0, 1'b1, 1'b0) | (21'h1 << F_FLEN_POS));
        load(fb_word(3, 0) | (21'h1 << GAIN_POS));
        check("gain set", pump_gain_bit, 1'b1);
        check("fast lock on", loop_filter_switch_out, 1'b0);
        load(fb_word(3, 0));
        check("gain cleared", pump_gain_bit, 1'b0);
        check("fast lock off", loop_filter_switch_out, 1'b1);
        $display("test fast lock pin done");
        @(posedge ref_clk);
        chip_enable <= 1'b0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check("powered down", powered_down, 1'b1);
        check("pump tristate", pump_tristate, 1'b1);
        check("shunt closed", ref_shunt_switch, 1'b1);
        check("series open", ref_series_switch, 1'b0);
        @(posedge ref_clk);
        chip_enable <= 1'b1;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check("powered up", powered_down, 1'b0);
        check("pump driven", pump_tristate, 1'b0);
        check("shunt open", ref_shunt_switch, 1'b0);
        check("series closed", ref_series_switch, 1'b1);
        $display("test chip enable done");
        print_verdict();
    end
endmodule
`default_nettype wire
